// ==== uce_pkg.sv ====
// shared constants, register map and state encodings for the serial control block
package uce_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam logic [APB_ADDR_W-1:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFS_DATA = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] OFS_BAUD = 8'h10;

  // ****************************************
  // serial_ctrl_two fields
  // ****************************************
  localparam int BIT_TX_EMPTY_IRQ_ON = 7;
  localparam int BIT_TX_DONE_IRQ_ON = 6;
  localparam int BIT_RX_FULL_IRQ_ON = 5;
  localparam int BIT_RX_QUIET_IRQ_ON = 4;
  localparam int BIT_TX_ON = 3;
  localparam int BIT_RX_ON = 2;
  localparam int BIT_RX_STANDBY = 1;
  localparam int BIT_BREAK_SEND = 0;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;

  // ****************************************
  // control one fields
  // ****************************************
  localparam int BIT_LOOPBACK = 7;
  localparam int BIT_RX_SOURCE = 5;
  localparam int BIT_CHAR_LENGTH = 4;
  localparam int BIT_RESUME_METHOD = 3;
  localparam int BIT_LONG_BREAK = 1;
  localparam int BIT_ONE_WIRE_DIR = 0;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;

  // ****************************************
  // status fields
  // ****************************************
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_TX_DONE = 6;
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_RX_QUIET = 4;

  // ****************************************
  // framing and timing
  // ****************************************
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] BAUD_RESET = 16'h0010;
  localparam int FRAME_W = 14;
  localparam logic [3:0] CHAR_BITS_EIGHT = 4'ha;
  localparam logic [3:0] CHAR_BITS_NINE = 4'hb;
  localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
  localparam logic [3:0] DATA_BITS_EIGHT = 4'h8;
  localparam logic [3:0] DATA_BITS_NINE = 4'h9;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } uce_rx_state_type;
endpackage

// ==== uce_tx_shift.sv ====
// transmit shifter for data, idle and break frames
`timescale 1ns/10ps
`default_nettype none
module uce_tx_shift
  import uce_pkg::*;
#(
  parameter int FW = FRAME_W,
  parameter int DW = DIV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing
  input wire logic [DW-1:0] bit_div,
  // frame load
  input wire logic load,
  input wire logic [FW-1:0] frame,
  input wire logic [3:0] nbits,
  // line side
  output logic line,
  output logic busy
);
  logic [FW-1:0] sh;
  logic [DW-1:0] cnt;
  logic [3:0] left;
  logic tick;

  // a zero divisor never ticks, so the shifter simply stalls
  assign tick = (cnt == {{(DW-1){1'b0}}, 1'b1});
  assign busy = (left != 4'h0);
  assign line = sh[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= {FW{1'b1}};
      left <= 4'h0;
      cnt <= {DW{1'b0}};
    end else if (load && !busy) begin
      sh <= frame;
      left <= nbits;
      cnt <= bit_div;
    end else if (busy) begin
      if (tick) begin
        sh <= {1'b1, sh[FW-1:1]};
        left <= left - 4'h1;
        cnt <= bit_div;
      end else if (cnt != {DW{1'b0}}) begin
        cnt <= cnt - {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ==== uce_rx_shift.sv ====
// receive shifter with idle line detection
`timescale 1ns/10ps
`default_nettype none
module uce_rx_shift
  import uce_pkg::*;
#(
  parameter int DW = DIV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic enable,
  input wire logic nine_bit,
  input wire logic [DW-1:0] bit_div,
  // line side
  input wire logic line,
  // results
  output logic char_valid,
  output logic [8:0] char_data,
  output logic quiet
);
  uce_rx_state_type state;
  logic [DW-1:0] cnt;
  logic [DW-1:0] half;
  logic [3:0] idx;
  logic [3:0] qbits;
  logic [8:0] sh;
  logic active;
  logic tick;
  logic [3:0] char_bits;

  assign tick = (cnt == {{(DW-1){1'b0}}, 1'b1});
  assign half = (bit_div[DW-1:1] == {(DW-1){1'b0}}) ? {{(DW-1){1'b0}}, 1'b1}
                                                   : {1'b0, bit_div[DW-1:1]};
  assign char_bits = nine_bit ? CHAR_BITS_NINE : CHAR_BITS_EIGHT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RX_IDLE;
      cnt <= {DW{1'b0}};
      idx <= 4'h0;
      sh <= 9'h000;
      char_valid <= 1'b0;
      char_data <= 9'h000;
    end else begin
      char_valid <= 1'b0;
      if (tick) begin
        cnt <= bit_div;
      end else if (cnt != {DW{1'b0}}) begin
        cnt <= cnt - {{(DW-1){1'b0}}, 1'b1};
      end else begin
        cnt <= bit_div;
      end
      case (state)
        RX_IDLE: begin
          if (enable && !line) begin
            state <= RX_START;
            cnt <= half;
          end
        end
        RX_START: begin
          if (tick) begin
            state <= line ? RX_IDLE : RX_DATA;
            idx <= nine_bit ? DATA_BITS_NINE : DATA_BITS_EIGHT;
          end
        end
        RX_DATA: begin
          if (tick) begin
            sh <= {line, sh[8:1]};
            idx <= idx - 4'h1;
            if (idx == 4'h1) begin
              state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            state <= RX_IDLE;
            char_valid <= 1'b1;
            char_data <= nine_bit ? sh : {1'b0, sh[8:1]};
          end
        end
        default: begin
          state <= RX_IDLE;
        end
      endcase
      if (!enable) begin
        state <= RX_IDLE;
      end
    end
  end

  // idle count starts after the stop bit, so trailing ones never shorten it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qbits <= 4'h0;
      active <= 1'b0;
      quiet <= 1'b0;
    end else begin
      quiet <= 1'b0;
      if (state != RX_IDLE || !line || !enable) begin
        qbits <= 4'h0;
        if (char_valid) begin
          active <= 1'b1;
        end
      end else if (tick && active) begin
        qbits <= qbits + 4'h1;
        if (qbits + 4'h1 == char_bits) begin
          quiet <= 1'b1;
          active <= 1'b0;
        end
      end
      if (char_valid) begin
        active <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== uce_top.sv ====
// serial control enables: registers, transmit queueing, wakeup and pin ownership
//
// Notes on behaviour
// - control two readable and writable any time
// - transmit-empty flag interrupts when enabled
// - transmit-done flag interrupts when enabled
// - receive-full flag interrupts when enabled
// - line-quiet flag interrupts when enabled
// - transmitter on drives output pin
// - one-wire mode direction bit steers shared line
// - transmitter off-on while busy queues idle
// - pin held until queued work finishes; only the frame in shift and pending idle or break hold it, not buffered data
// - receiver off releases input pin
// - loopback releases input pin regardless
// - standby bit parks receiver awaiting wakeup
// - wakeup: idle line or address bit
// - wakeup clears standby bit in hardware
// - break bit set then clear queues break
// - break held queues further breaks, long option
// - eight or nine data bits, lsb first
// - internal loopback feeds transmitter to receiver
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module uce_top
  import uce_pkg::*;
#(
  parameter logic [DIV_W-1:0] BAUD_DEFAULT = BAUD_RESET
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_ADDR_W-1:0] PADDR,
  input wire logic [APB_DATA_W-1:0] PWDATA,
  output logic [APB_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // transmit pin, shared line in one-wire mode
  input wire logic TXD_IN,
  output logic TXD_OUT,
  output logic TXD_OE,
  output logic TXD_OWN,
  // receive pin
  input wire logic RXD_IN,
  output logic RXD_OWN,
  // interrupt request
  output logic IRQ
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_ff1;
  logic rst_n;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_ff1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_n <= rst_ff1;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_filt;

  assign pin_raw = {TXD_IN, RXD_IN};

  // a change is taken only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          pin_filt[gi] <= 1'b1;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_filt[gi] <= s3;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // apb decode
  // ****************************************
  function automatic logic hit(input logic [APB_ADDR_W-1:0] a,
                               input logic [APB_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [APB_ADDR_W-1:0] a);
    mapped = hit(a, OFS_CTRL_ONE) || hit(a, OFS_CTRL_TWO) || hit(a, OFS_STATUS) ||
             hit(a, OFS_DATA) || hit(a, OFS_BAUD);
  endfunction

  logic access;
  logic wr_ev;
  logic rd_ev;

  // zero wait states; the answer is ready in the first access cycle
  assign PREADY = 1'b1;
  assign access = PSEL && PENABLE;
  assign wr_ev = access && PWRITE && mapped(PADDR);
  assign rd_ev = access && !PWRITE && mapped(PADDR);
  assign PSLVERR = access && !mapped(PADDR);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl_two;
  logic [7:0] ctrl_one;
  logic [DIV_W-1:0] baud_div;
  logic [8:0] tx_buf;
  logic [8:0] rx_data;
  logic tx_buffer_empty_flag;
  logic tx_done_flag;
  logic rx_full_flag;
  logic rx_quiet_flag;
  logic wr_ctrl_two;
  logic data_wr;
  logic data_rd;
  logic [7:0] status;

  assign wr_ctrl_two = wr_ev && hit(PADDR, OFS_CTRL_TWO);
  assign data_wr = wr_ev && hit(PADDR, OFS_DATA);
  assign data_rd = rd_ev && hit(PADDR, OFS_DATA);

  logic tx_on_bit;
  logic rx_on_bit;
  logic break_send_bit;
  logic loopback_select;
  logic rx_source_select;
  logic char_length_select;
  logic rx_resume_method;
  logic long_break_select;
  logic one_wire_direction;
  logic one_wire;

  assign tx_on_bit = ctrl_two[BIT_TX_ON];
  assign rx_on_bit = ctrl_two[BIT_RX_ON];
  assign break_send_bit = ctrl_two[BIT_BREAK_SEND];
  assign loopback_select = ctrl_one[BIT_LOOPBACK];
  assign rx_source_select = ctrl_one[BIT_RX_SOURCE];
  assign char_length_select = ctrl_one[BIT_CHAR_LENGTH];
  assign rx_resume_method = ctrl_one[BIT_RESUME_METHOD];
  assign long_break_select = ctrl_one[BIT_LONG_BREAK];
  assign one_wire_direction = ctrl_one[BIT_ONE_WIRE_DIR];
  assign one_wire = loopback_select && rx_source_select;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one <= CTRL_ONE_RESET;
      baud_div <= BAUD_DEFAULT;
    end else if (wr_ev) begin
      if (hit(PADDR, OFS_CTRL_ONE)) begin
        ctrl_one <= PWDATA[7:0];
      end
      if (hit(PADDR, OFS_BAUD)) begin
        baud_div <= PWDATA[DIV_W-1:0];
      end
    end
  end

  // ****************************************
  // receiver path and standby
  // ****************************************
  logic rx_line;
  logic char_valid;
  logic [8:0] char_data;
  logic quiet;
  logic char_msb;
  logic wake;
  logic accept;
  logic tx_line;
  logic tx_busy;

  // internal loopback, one-wire line, or the receive pin
  assign rx_line = one_wire ? pin_filt[1] : (loopback_select ? tx_line : pin_filt[0]);
  assign char_msb = char_length_select ? char_data[8] : char_data[7];
  assign wake = ctrl_two[BIT_RX_STANDBY] &&
                (rx_resume_method ? (char_valid && char_msb) : quiet);
  assign accept = char_valid && (!ctrl_two[BIT_RX_STANDBY] || wake);

  uce_rx_shift #(
    .DW(DIV_W)
  ) u_rx (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .enable(rx_on_bit),
    .nine_bit(char_length_select),
    .bit_div(baud_div),
    .line(rx_line),
    .char_valid(char_valid),
    .char_data(char_data),
    .quiet(quiet)
  );

  // control two: a software write overrides the hardware wakeup clear
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two <= CTRL_TWO_RESET;
    end else if (wr_ctrl_two) begin
      ctrl_two <= PWDATA[7:0];
    end else if (wake) begin
      ctrl_two[BIT_RX_STANDBY] <= 1'b0;
    end
  end

  // received data and flags; the set wins over the read clear
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 9'h000;
      rx_full_flag <= 1'b0;
      rx_quiet_flag <= 1'b0;
    end else begin
      if (data_rd) begin
        rx_full_flag <= 1'b0;
        rx_quiet_flag <= 1'b0;
      end
      // without room the new character is dropped; a read in the same cycle makes room
      if (accept && (!rx_full_flag || data_rd)) begin
        rx_data <= char_data;
        rx_full_flag <= 1'b1;
      end
      if (quiet && !ctrl_two[BIT_RX_STANDBY]) begin
        rx_quiet_flag <= 1'b1;
      end
    end
  end

  // ****************************************
  // transmit queueing
  // ****************************************
  logic break_pend;
  logic idle_pend;
  logic tx_load;
  logic [FRAME_W-1:0] tx_frame;
  logic [3:0] tx_nbits;
  logic [3:0] char_bits;
  logic next_tx_on;
  logic next_break;

  assign char_bits = char_length_select ? CHAR_BITS_NINE : CHAR_BITS_EIGHT;
  assign next_tx_on = PWDATA[BIT_TX_ON];
  assign next_break = PWDATA[BIT_BREAK_SEND];

  // low n bits of zero followed by ones
  function automatic logic [FRAME_W-1:0] break_frame(input logic [3:0] n);
    logic [FRAME_W-1:0] f;
    f = {FRAME_W{1'b1}};
    for (int i = 0; i < FRAME_W; i++) begin
      f[i] = (i >= int'(n));
    end
    break_frame = f;
  endfunction

  function automatic logic [FRAME_W-1:0] data_frame(input logic nine,
                                                    input logic [8:0] d);
    logic [FRAME_W-1:0] f;
    f = {FRAME_W{1'b1}};
    f[0] = 1'b0;
    f[8:1] = d[7:0];
    if (nine) begin
      f[9] = d[8];
    end
    data_frame = f;
  endfunction

  // break first, then the idle preamble, then buffered data
  always_comb begin
    tx_load = 1'b0;
    tx_frame = {FRAME_W{1'b1}};
    tx_nbits = char_bits;
    if (!tx_busy) begin
      if (break_pend) begin
        tx_load = 1'b1;
        tx_nbits = long_break_select ? char_bits + LONG_BREAK_EXTRA : char_bits;
        tx_frame = break_frame(tx_nbits);
      end else if (idle_pend) begin
        tx_load = 1'b1;
      end else if (tx_on_bit && !tx_buffer_empty_flag && !data_wr) begin
        tx_load = 1'b1;
        tx_frame = data_frame(char_length_select, tx_buf);
      end
    end
  end

  // a second break may slip in if the bit is still set at reload
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      break_pend <= 1'b0;
      idle_pend <= 1'b0;
    end else begin
      if (tx_load && break_pend) begin
        break_pend <= break_send_bit;
      end else if (tx_load) begin
        idle_pend <= 1'b0;
      end
      if (wr_ctrl_two && next_break && !break_send_bit) begin
        break_pend <= 1'b1;
      end
      if (wr_ctrl_two && next_tx_on && !tx_on_bit) begin
        idle_pend <= 1'b1;
      end
    end
  end

  // data loads are held off in a data write cycle, so set and clear never meet
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
    end else begin
      if (data_wr) begin
        tx_buf <= PWDATA[8:0];
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_load && !break_pend && !idle_pend) begin
        tx_buffer_empty_flag <= 1'b1;
      end
      tx_done_flag <= tx_buffer_empty_flag && !data_wr && !tx_busy && !tx_load &&
                      !break_pend && !idle_pend;
    end
  end

  uce_tx_shift #(
    .FW(FRAME_W),
    .DW(DIV_W)
  ) u_tx (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .bit_div(baud_div),
    .load(tx_load),
    .frame(tx_frame),
    .nbits(tx_nbits),
    .line(tx_line),
    .busy(tx_busy)
  );

  // ****************************************
  // pin ownership
  // ****************************************
  logic tx_owned;

  assign tx_owned = tx_on_bit || tx_busy || break_pend || idle_pend;
  assign TXD_OWN = tx_owned;
  assign TXD_OUT = tx_line;
  assign TXD_OE = tx_owned && (!one_wire || one_wire_direction);
  assign RXD_OWN = rx_on_bit && !loopback_select;

  // ****************************************
  // status, read data and interrupt
  // ****************************************
  assign status = {tx_buffer_empty_flag, tx_done_flag, rx_full_flag, rx_quiet_flag, 4'h0};

  // read data is captured in the setup cycle and stands through the access cycle
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= {APB_DATA_W{1'b0}};
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {APB_DATA_W{1'b0}};
      if (hit(PADDR, OFS_CTRL_ONE)) begin
        PRDATA[7:0] <= ctrl_one;
      end
      if (hit(PADDR, OFS_CTRL_TWO)) begin
        PRDATA[7:0] <= ctrl_two;
      end
      if (hit(PADDR, OFS_STATUS)) begin
        PRDATA[7:0] <= status;
      end
      if (hit(PADDR, OFS_DATA)) begin
        PRDATA[8:0] <= rx_data;
      end
      if (hit(PADDR, OFS_BAUD)) begin
        PRDATA[DIV_W-1:0] <= baud_div;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (ctrl_two[BIT_TX_EMPTY_IRQ_ON] && tx_buffer_empty_flag) ||
             (ctrl_two[BIT_TX_DONE_IRQ_ON] && tx_done_flag) ||
             (ctrl_two[BIT_RX_FULL_IRQ_ON] && rx_full_flag) ||
             (ctrl_two[BIT_RX_QUIET_IRQ_ON] && rx_quiet_flag);
    end
  end
endmodule
`default_nettype wire

// ==== uce_properties.sv ====
// port checker for the serial control block
`timescale 1ns/10ps
`default_nettype none
module uce_properties
  import uce_pkg::*;
(
  // clock, reset and bus
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pins and request
  input wire logic TXD_IN,
  input wire logic TXD_OUT,
  input wire logic TXD_OE,
  input wire logic TXD_OWN,
  input wire logic RXD_IN,
  input wire logic RXD_OWN,
  input wire logic IRQ
);
  // ****
  // shadow of software writes
  // ****
  // standby bit is left out of compares: hardware may clear it
  logic [7:0] c1;
  logic [7:0] c2;
  logic acc;
  logic map;
  assign acc = PSEL && PENABLE;
  assign map = PADDR inside {OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_STATUS, OFS_DATA, OFS_BAUD};
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      c1 <= CTRL_ONE_RESET;
      c2 <= CTRL_TWO_RESET;
    end else if (acc && PWRITE && PADDR == OFS_CTRL_ONE) begin
      c1 <= PWDATA[7:0];
    end else if (acc && PWRITE && PADDR == OFS_CTRL_TWO) begin
      c2 <= PWDATA[7:0];
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  AST_READY: assert property (PSEL |-> PREADY) else $error("ready low");
  AST_UNMAP: assert property (acc && !map |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access");
  AST_MAPOK: assert property (acc && map |-> !PSLVERR) else $error("mapped refused");
  AST_RD2: assert property (acc && !PWRITE && PADDR == OFS_CTRL_TWO |->
    PRDATA[31:8] == 24'h0 && PRDATA[7:2] == c2[7:2] && PRDATA[0] == c2[0])
    else $error("control two readback");
  AST_RXOWN: assert property (RXD_OWN == (c2[BIT_RX_ON] && !c1[BIT_LOOPBACK]))
    else $error("rx pin ownership");
  AST_OE: assert property (TXD_OE == (TXD_OWN &&
    !(c1[BIT_LOOPBACK] && c1[BIT_RX_SOURCE] && !c1[BIT_ONE_WIRE_DIR])))
    else $error("tx enable");
  AST_TXON: assert property (c2[BIT_TX_ON] && $past(c2[BIT_TX_ON]) |-> TXD_OWN)
    else $error("tx on not owned");
  AST_REL: assert property ($fell(TXD_OWN) |-> !c2[BIT_TX_ON] && TXD_OUT)
    else $error("early release");
  AST_LINE: assert property (!TXD_OWN |-> TXD_OUT) else $error("line low unowned");
  AST_IRQOFF: assert property (c2[7:4] == 4'h0 && $past(c2[7:4]) == 4'h0 |-> !IRQ)
    else $error("irq without enable");
  cover property (acc && PWRITE && PADDR == OFS_DATA);
  cover property ($fell(TXD_OWN));
  cover property ($rose(IRQ));
endmodule
`default_nettype wire

// ==== uce_remote.sv ====
// remote serial station: sends characters, captures frames
`timescale 1ns/10ps
`default_nettype none
module uce_remote #(
  parameter int BIT = 4
) (
  // clock
  input wire logic clk,
  // line
  input wire logic tx,
  output logic rx,
  // observations
  output logic [8:0] got,
  output int frames,
  output int low_run,
  output int hi_run
);
  int z;
  logic pt;
  initial begin
    rx = 1'h1;
    got = 9'h000;
    frames = 0;
    low_run = 0;
    hi_run = 0;
    z = 0;
    pt = 1'h1;
  end
  // ****
  // run lengths measure break and idle time
  // ****
  always @(posedge clk) begin
    if (tx !== pt) begin
      if (pt) hi_run = z;
      else low_run = z;
      z = 0;
    end
    z = z + 1;
    pt = tx;
  end
  // nine samples: in eight-bit frames the last one is the stop bit
  always begin
    @(negedge tx);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = tx;
    end
    frames = frames + 1;
  end
  // start, nine bits lsb first, stop; eight-bit callers put 1 in bit 8
  task automatic send(input logic [8:0] ch);
    logic [10:0] f;
    f = {1'h1, ch, 1'h0};
    for (int i = 0; i < 11; i++) begin
      rx <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== test_uart_control_enables.sv ====
// self-checking bench for the serial control block
`timescale 1ns/10ps
`default_nettype none
module test_uart_control_enables
  import uce_pkg::*;
;
  typedef struct packed {logic [7:0] c2; logic irq; logic own; logic rxo;} uce_row_type;
  uce_row_type rows [6] = '{'{8'h80, 1'h1, 1'h0, 1'h0}, '{8'h40, 1'h1, 1'h0, 1'h0},
    '{8'h20, 1'h0, 1'h0, 1'h0}, '{8'h10, 1'h0, 1'h0, 1'h0},
    '{8'h04, 1'h0, 1'h0, 1'h1}, '{8'h08, 1'h0, 1'h1, 1'h0}};
  logic [7:0] bc [3] = '{8'h00, 8'h02, 8'h10};
  int bl [3] = '{40, 52, 44};
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, txd_in, txd_out, txd_oe, txd_own, rxd_in, rxd_own, irq;
  logic [8:0] got;
  int frames, low_run, hi_run, n;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // shared line pulled up when nobody drives it
  assign txd_in = txd_oe ? txd_out : 1'h1;
  always #2.5 clk = ~clk;
  uce_top #(.BAUD_DEFAULT(16'h0004)) dut (
    .SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TXD_IN(txd_in), .TXD_OUT(txd_out), .TXD_OE(txd_oe), .TXD_OWN(txd_own),
    .RXD_IN(rxd_in), .RXD_OWN(rxd_own), .IRQ(irq));
  uce_remote #(.BIT(4)) far (.clk(clk), .tx(txd_out), .rx(rxd_in), .got(got),
    .frames(frames), .low_run(low_run), .hi_run(hi_run));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****
  // bus and wait helpers
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'h1 && t < 50);
    rd = prdata;
    err = pslverr;
    check(pready, 1'h1);
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (irq !== 1'h1 && t < 500) begin
      @(posedge clk);
      t++;
    end
    check(irq, 1'h1);
  endtask
  task automatic wait_frames(input int k);
    int t;
    t = 0;
    while (frames < k && t < 1000) begin
      @(posedge clk);
      t++;
    end
    check(frames >= k, 1'h1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    rdr(OFS_CTRL_TWO);
    check(rd, {24'h0, CTRL_TWO_RESET});
    check({txd_out, irq, txd_own}, 3'h4);
    wr(8'h40, 32'hff);
    check(err, 1'h1);
    rdr(8'h40);
    check({err, rd}, {1'h1, 32'h0});
    foreach (rows[i]) begin
      wr(OFS_CTRL_TWO, rows[i].c2);
      rdr(OFS_CTRL_TWO);
      check(rd, rows[i].c2);
      check(irq, rows[i].irq);
      check({txd_own, txd_oe}, {2{rows[i].own}});
      check(rxd_own, rows[i].rxo);
    end
    wr(OFS_CTRL_ONE, 8'h10);
    n = frames;
    wr(OFS_DATA, 9'h1a5);
    wait_frames(n + 1);
    check(got, 9'h1a5);
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_DATA, 8'h5a);
    wr(OFS_CTRL_TWO, 8'h00);
    check(txd_own, 1'h1);
    wait_frames(n + 2);
    check(got, 9'h15a);
    repeat (20) @(posedge clk);
    check({txd_own, txd_out}, 2'h1);
    wr(OFS_CTRL_TWO, 8'h08);
    repeat (60) @(posedge clk);
    n = frames;
    wr(OFS_DATA, 8'h11);
    wr(OFS_CTRL_TWO, 8'h00);
    wr(OFS_CTRL_TWO, 8'h08);
    wr(OFS_DATA, 8'h80);
    wait_frames(n + 2);
    check(got, 9'h180);
    check(hi_run >= 44, 1'h1);
    // break set and cleared behind data, so only one break is queued
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL_ONE, bc[i]);
      n = frames;
      wr(OFS_DATA, 8'h77);
      wr(OFS_CTRL_TWO, 8'h09);
      wr(OFS_CTRL_TWO, 8'h08);
      wait_frames(n + 2);
      repeat (20) @(posedge clk);
      check(low_run, bl[i]);
    end
    n = frames;
    wr(OFS_CTRL_TWO, 8'h09);
    repeat (200) @(posedge clk);
    wr(OFS_CTRL_TWO, 8'h08);
    repeat (100) @(posedge clk);
    check(low_run > 80 || frames > n + 2, 1'h1);
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_CTRL_TWO, 8'h34);
    far.send(9'h155);
    wait_irq();
    rdr(OFS_DATA);
    check(rd, 32'h55);
    repeat (2) @(posedge clk);
    check(irq, 1'h0);
    wait_irq();
    rdr(OFS_STATUS);
    check(rd[5:4], 2'h1);
    rdr(OFS_DATA);
    wr(OFS_CTRL_TWO, 8'h26);
    far.send(9'h1aa);
    check(irq, 1'h0);
    repeat (80) @(posedge clk);
    rdr(OFS_CTRL_TWO);
    check(rd, 32'h24);
    wr(OFS_CTRL_ONE, 8'h08);
    wr(OFS_CTRL_TWO, 8'h26);
    far.send(9'h105);
    rdr(OFS_CTRL_TWO);
    check({irq, rd}, {1'h0, 32'h26});
    far.send(9'h185);
    wait_irq();
    rdr(OFS_DATA);
    check(rd, 32'h85);
    rdr(OFS_CTRL_TWO);
    check(rd, 32'h24);
    wr(OFS_CTRL_ONE, 8'h80);
    wr(OFS_CTRL_TWO, 8'h2c);
    check(rxd_own, 1'h0);
    wr(OFS_DATA, 8'h3c);
    wait_irq();
    rdr(OFS_DATA);
    check(rd, 32'h3c);
    wr(OFS_CTRL_ONE, 8'ha0);
    check(txd_oe, 1'h0);
    wr(OFS_CTRL_ONE, 8'ha1);
    check(txd_oe, 1'h1);
    conclude();
  end
endmodule
bind uce_top uce_properties chk (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TXD_IN(TXD_IN), .TXD_OUT(TXD_OUT), .TXD_OE(TXD_OE), .TXD_OWN(TXD_OWN),
  .RXD_IN(RXD_IN), .RXD_OWN(RXD_OWN), .IRQ(IRQ));
`default_nettype wire
